/* core/nss_pkg.sv */
// Constants and types for the nibble swap and subtract unit
// Contract
// - Swap output: low nibble up, high down
// - Dest bit zero writes accumulator only
// - Dest bit one writes register back
// - Positive difference sets carry to one
// - Equal operands: zero result, carry one
// - Borrow clears carry, result wraps modulo 256
// - Register minus accumulator, placed by dest
// - Literal minus accumulator, always to accumulator
package nss_pkg;
   localparam int DATA_W = 8;
   localparam int NIB_W = 4;
   localparam int NIB_LO = 0;
   localparam int NIB_HI = 4;
   localparam int ADDR_W = 7;
   localparam logic [DATA_W-1:0] ACCUM_RST = 8'h00;
   localparam logic CARRY_RST = 1'h0;
   localparam logic DEST_ACCUM = 1'h0;
   localparam logic DEST_FILE = 1'h1;
   typedef enum logic [1:0] {
      NSS_OP_NONE,
      NSS_OP_NIBBLE_EXCHANGE,
      NSS_OP_FILE_MINUS_ACCUM,
      NSS_OP_LITERAL_MINUS_ACCUM
   } nss_op_e;
endpackage : nss_pkg

/* core/nss_subtractor.sv */
// Eight-bit subtractor with not-borrow carry out
`timescale 1ns/100ps
module nss_subtractor (
   // Operands
   input wire logic [nss_pkg::DATA_W-1:0] i_minuend,
   input wire logic [nss_pkg::DATA_W-1:0] i_subtrahend,
   // Result
   output logic [nss_pkg::DATA_W-1:0] o_diff,
   output logic o_not_borrow
);
   logic [nss_pkg::DATA_W:0] wide;

   // Ninth bit of minuend plus inverted subtrahend plus one is not-borrow
   always_comb begin
      wide = {1'h0, i_minuend} + {1'h0, ~i_subtrahend} + 9'h001;
      o_diff = wide[nss_pkg::DATA_W-1:0];
      o_not_borrow = wide[nss_pkg::DATA_W];
   end
endmodule : nss_subtractor

/* core/nss_unit.sv */
// Nibble exchange and subtract datapath with accumulator and carry
`timescale 1ns/100ps
module nss_unit (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   // Decoded instruction, one per cycle
   input wire logic i_op_valid,
   input wire nss_pkg::nss_op_e i_op,
   input wire logic i_dest_sel,
   input wire logic [nss_pkg::ADDR_W-1:0] i_file_addr,
   input wire logic [nss_pkg::DATA_W-1:0] i_literal,
   // Register file read data for i_file_addr
   input wire logic [nss_pkg::DATA_W-1:0] i_file_rdata,
   // Register file write port
   output logic o_file_we,
   output logic [nss_pkg::ADDR_W-1:0] o_file_waddr,
   output logic [nss_pkg::DATA_W-1:0] o_file_wdata,
   // Accumulator and carry state
   output logic [nss_pkg::DATA_W-1:0] o_accum,
   output logic o_carry
);
   // Registered state
   logic [nss_pkg::DATA_W-1:0] accum_q;
   logic carry_q;
   logic file_we_q;
   logic [nss_pkg::ADDR_W-1:0] file_waddr_q;
   logic [nss_pkg::DATA_W-1:0] file_wdata_q;
   // Next values of the registered state
   logic [nss_pkg::DATA_W-1:0] accum_d;
   logic carry_d;
   logic file_we_d;
   logic [nss_pkg::ADDR_W-1:0] file_waddr_d;
   logic [nss_pkg::DATA_W-1:0] file_wdata_d;
   // Datapath
   logic [nss_pkg::DATA_W-1:0] swapped;
   logic [nss_pkg::DATA_W-1:0] minuend;
   logic [nss_pkg::DATA_W-1:0] diff;
   logic not_borrow;
   logic [nss_pkg::DATA_W-1:0] result_d;
   logic to_file_d;
   // Decoded instruction
   logic is_swap;
   logic is_file_sub;
   logic is_lit_sub;
   logic is_sub;
   logic is_op;
   logic accum_we;
   logic carry_we;

   // Idle and unknown codes decode to no operation
   always_comb begin
      is_swap = 1'h0;
      is_file_sub = 1'h0;
      is_lit_sub = 1'h0;
      case (i_op)
         nss_pkg::NSS_OP_NIBBLE_EXCHANGE: begin
            is_swap = i_op_valid;
         end
         nss_pkg::NSS_OP_FILE_MINUS_ACCUM: begin
            is_file_sub = i_op_valid;
         end
         nss_pkg::NSS_OP_LITERAL_MINUS_ACCUM: begin
            is_lit_sub = i_op_valid;
         end
         default: begin
            is_swap = 1'h0;
         end
      endcase
   end

   assign is_sub = is_file_sub || is_lit_sub;
   assign is_op = is_swap || is_sub;

   // Each bit of one nibble takes the same place in the other
   for (genvar b = 0; b < nss_pkg::NIB_W; b = b + 1) begin : g_swap
      assign swapped[nss_pkg::NIB_HI + b] =
         i_file_rdata[nss_pkg::NIB_LO + b];
      assign swapped[nss_pkg::NIB_LO + b] =
         i_file_rdata[nss_pkg::NIB_HI + b];
   end

   // Literal form takes the immediate as minuend
   always_comb begin
      if (is_lit_sub) begin
         minuend = i_literal;
      end else begin
         minuend = i_file_rdata;
      end
   end

   // Subtrahend is the live accumulator, so back-to-back ops chain
   nss_subtractor nss_subtractor_inst (
      .i_minuend(minuend),
      .i_subtrahend(accum_q),
      .o_diff(diff),
      .o_not_borrow(not_borrow)
   );

   // Swap bypasses the subtractor
   always_comb begin
      result_d = diff;
      case (i_op)
         nss_pkg::NSS_OP_NIBBLE_EXCHANGE: begin
            result_d = swapped;
         end
         nss_pkg::NSS_OP_FILE_MINUS_ACCUM: begin
            result_d = diff;
         end
         nss_pkg::NSS_OP_LITERAL_MINUS_ACCUM: begin
            result_d = diff;
         end
         default: begin
            result_d = diff;
         end
      endcase
   end

   // Literal form has no destination bit, so its select is ignored
   always_comb begin
      to_file_d = 1'h0;
      case (i_op)
         nss_pkg::NSS_OP_NIBBLE_EXCHANGE: begin
            to_file_d = (i_dest_sel == nss_pkg::DEST_FILE);
         end
         nss_pkg::NSS_OP_FILE_MINUS_ACCUM: begin
            to_file_d = (i_dest_sel == nss_pkg::DEST_FILE);
         end
         nss_pkg::NSS_OP_LITERAL_MINUS_ACCUM: begin
            to_file_d = 1'h0;
         end
         default: begin
            to_file_d = 1'h0;
         end
      endcase
   end

   // Write enables of the accumulator and carry
   assign accum_we = is_op && !to_file_d;
   assign carry_we = is_sub;

   // Accumulator holds when the result goes to the register file
   always_comb begin
      if (accum_we) begin
         accum_d = result_d;
      end else begin
         accum_d = accum_q;
      end
   end

   // Swap never touches carry
   always_comb begin
      if (carry_we) begin
         carry_d = not_borrow;
      end else begin
         carry_d = carry_q;
      end
   end

   // Write-back strobe lasts one cycle per file-destined op
   always_comb begin
      file_we_d = is_op && to_file_d;
   end

   // Address and data hold between writes for a slow register file
   always_comb begin
      if (file_we_d) begin
         file_waddr_d = i_file_addr;
         file_wdata_d = result_d;
      end else begin
         file_waddr_d = file_waddr_q;
         file_wdata_d = file_wdata_q;
      end
   end

   // Accumulator register
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         accum_q <= nss_pkg::ACCUM_RST;
      end else begin
         accum_q <= accum_d;
      end
   end

   // Carry register, not-borrow sense
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         carry_q <= nss_pkg::CARRY_RST;
      end else begin
         carry_q <= carry_d;
      end
   end

   // Registered strobe keeps the write port free of decode glitches
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         file_we_q <= 1'h0;
      end else begin
         file_we_q <= file_we_d;
      end
   end

   // Write address register
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         file_waddr_q <= '0;
      end else begin
         file_waddr_q <= file_waddr_d;
      end
   end

   // Write data register
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         file_wdata_q <= '0;
      end else begin
         file_wdata_q <= file_wdata_d;
      end
   end

   assign o_file_we = file_we_q;
   assign o_file_waddr = file_waddr_q;
   assign o_file_wdata = file_wdata_q;
   assign o_accum = accum_q;
   assign o_carry = carry_q;
endmodule : nss_unit

/* testbench/nss_unit_monitor.sv */
// Assertion checker for the nibble swap and subtract unit
`timescale 1ns/100ps
module nss_unit_monitor (
   input wire logic i_core_clk, i_rst_n, i_op_valid, i_dest_sel,
   input wire nss_pkg::nss_op_e i_op,
   input wire logic [6:0] i_file_addr, o_file_waddr,
   input wire logic [7:0] i_literal, i_file_rdata, o_file_wdata, o_accum,
   input wire logic o_file_we, o_carry
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   wire sw = i_op_valid && i_op == nss_pkg::NSS_OP_NIBBLE_EXCHANGE;
   wire lt = i_op_valid && i_op == nss_pkg::NSS_OP_LITERAL_MINUS_ACCUM;
   wire fs = i_op_valid && i_op == nss_pkg::NSS_OP_FILE_MINUS_ACCUM;
   wire [7:0] mnd = lt ? i_literal : i_file_rdata;
   wire [7:0] swp = {i_file_rdata[3:0], i_file_rdata[7:4]};
   // Write-back lands one cycle on, accumulator untouched
   sequence s_wb;
      ##1 o_file_we && $stable(o_accum);
   endsequence
   chk_swap_accum: assert property (sw && !i_dest_sel |=>
      o_accum == $past(swp) && !o_file_we) else $error("swap to accum");
   chk_swap_file: assert property (sw && i_dest_sel |-> s_wb ##0
      o_file_wdata == $past(swp) && o_file_waddr == $past(i_file_addr))
      else $error("swap write-back");
   chk_swap_carry: assert property (sw |=> $stable(o_carry))
      else $error("swap moved carry");
   chk_lit_sub: assert property (lt |=>
      o_accum == $past(i_literal - o_accum)) else $error("literal sub");
   chk_file_sub: assert property (fs && i_dest_sel |-> s_wb ##0
      o_file_wdata == $past(i_file_rdata - o_accum)) else $error("file sub");
   chk_no_borrow: assert property ((lt || fs) && mnd >= o_accum
      |=> o_carry) else $error("carry not set");
   chk_borrow_clear: assert property ((lt || fs) && mnd < o_accum
      |=> !o_carry) else $error("carry not cleared");
   chk_equal_zero: assert property ((lt || fs && !i_dest_sel)
      && mnd == o_accum |=> o_accum == 8'h00) else $error("equal not zero");
   chk_we_quiet: assert property (!((sw || fs) && i_dest_sel)
      |=> !o_file_we) else $error("stray write");
endmodule : nss_unit_monitor

/* testbench/test_nss_unit.sv */
// Directed testbench for the nibble swap and subtract unit
`timescale 1ns/100ps
module test_nss_unit;
   logic i_core_clk = 0, i_rst_n = 0, i_op_valid = 0, i_dest_sel = 0;
   nss_pkg::nss_op_e i_op = nss_pkg::NSS_OP_NONE;
   logic [6:0] i_file_addr = 7'h00, o_file_waddr;
   logic [7:0] i_literal = 8'h00, i_file_rdata = 8'h00, o_file_wdata, o_accum;
   logic o_file_we, o_carry;
   int err_count = 0, check_count = 0;
   localparam nss_pkg::nss_op_e SW = nss_pkg::NSS_OP_NIBBLE_EXCHANGE;
   localparam nss_pkg::nss_op_e FS = nss_pkg::NSS_OP_FILE_MINUS_ACCUM;
   localparam nss_pkg::nss_op_e LT = nss_pkg::NSS_OP_LITERAL_MINUS_ACCUM;
   nss_unit nss_unit_inst (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_op_valid(i_op_valid),
      .i_op(i_op),
      .i_dest_sel(i_dest_sel),
      .i_file_addr(i_file_addr),
      .i_literal(i_literal),
      .i_file_rdata(i_file_rdata),
      .o_file_we(o_file_we),
      .o_file_waddr(o_file_waddr),
      .o_file_wdata(o_file_wdata),
      .o_accum(o_accum),
      .o_carry(o_carry)
   );
   initial forever #5 i_core_clk = ~i_core_clk;
   task automatic chk(string n, logic [7:0] e, g);
      check_count++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %s exp %h got %h", n, e, g);
      end
   endtask : chk
   // Idle cycle between ops also proves valid low is ignored
   task automatic run(nss_pkg::nss_op_e op, logic d, logic [7:0] r);
      @(negedge i_core_clk);
      i_op_valid = 1;
      i_op = op;
      i_dest_sel = d;
      i_file_rdata = r;
      i_literal = r;
      i_file_addr = r[6:0];
      @(negedge i_core_clk);
      i_op_valid = 0;
   endtask : run
   task automatic t_swap;
      run(SW, 0, 8'ha5);
      chk("accum", 8'h5a, o_accum);
      run(SW, 1, 8'hc3);
      chk("we", 8'h01, o_file_we);
      chk("wdata", 8'h3c, o_file_wdata);
      chk("waddr", 8'h43, o_file_waddr);
      chk("accum", 8'h5a, o_accum);
   endtask : t_swap
   // Idle code with valid high, then a live code with valid low
   task automatic t_refuse;
      @(negedge i_core_clk);
      i_op_valid = 1;
      i_op = nss_pkg::NSS_OP_NONE;
      i_file_rdata = 8'h00;
      i_literal = 8'h00;
      @(negedge i_core_clk);
      chk("idle_we", 8'h00, o_file_we);
      chk("idle_accum", 8'h5a, o_accum);
      i_op_valid = 0;
      i_op = LT;
      @(negedge i_core_clk);
      chk("hold_accum", 8'h5a, o_accum);
      chk("hold_carry", 8'h00, o_carry);
      chk("hold_we", 8'h00, o_file_we);
   endtask : t_refuse
   task automatic sub(nss_pkg::nss_op_e op, logic d, logic [7:0] a, m, e,
                      logic c, pc);
      run(SW, 0, {a[3:0], a[7:4]});
      chk("swap_carry", pc, o_carry);
      run(op, d, m);
      chk("carry", c, o_carry);
      chk("we", d && op != LT, o_file_we);
      chk("result", e, d && op != LT ? o_file_wdata : o_accum);
      if (d && op != LT) chk("accum", a, o_accum);
   endtask : sub
   task automatic give_verdict;
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : give_verdict
   initial begin
      repeat (4) @(negedge i_core_clk);
      chk("rst_accum", nss_pkg::ACCUM_RST, o_accum);
      chk("rst_carry", nss_pkg::CARRY_RST, o_carry);
      chk("rst_we", 8'h00, o_file_we);
      i_rst_n = 1;
      t_swap();
      t_refuse();
      sub(LT, 0, 8'h02, 8'h03, 8'h01, 1, 0);
      sub(LT, 0, 8'h02, 8'h02, 8'h00, 1, 1);
      sub(LT, 0, 8'h03, 8'h02, 8'hff, 0, 1);
      sub(FS, 1, 8'h02, 8'h01, 8'hff, 0, 0);
      sub(FS, 0, 8'h02, 8'h03, 8'h01, 1, 0);
      sub(LT, 1, 8'h05, 8'h07, 8'h02, 1, 1);
      give_verdict();
   end
   initial begin
      #5000;
      err_count++;
      give_verdict();
   end
endmodule : test_nss_unit
bind nss_unit nss_unit_monitor nss_unit_monitor_inst (
   .i_core_clk(i_core_clk),
   .i_rst_n(i_rst_n),
   .i_op_valid(i_op_valid),
   .i_dest_sel(i_dest_sel),
   .i_op(i_op),
   .i_file_addr(i_file_addr),
   .o_file_waddr(o_file_waddr),
   .i_literal(i_literal),
   .i_file_rdata(i_file_rdata),
   .o_file_wdata(o_file_wdata),
   .o_accum(o_accum),
   .o_file_we(o_file_we),
   .o_carry(o_carry)
);
